// ==== spisc_top.sv ====
/*
  Serial master configuration slice: slave select latching, bit clock
  divider, transmit threshold event, master enable and interrupt logic.
  Assumes start, done and transmit level come from logic on clk.
*/
//
// Behaviour
// - Three-bit select field, one bit per chip select line, one means selected.
// - At transfer start every selected chip select line goes active.
// - Select writes change the lines only at the next transfer start.
// - A sixteen-bit divider sets the serial bit clock rate.
// - Divider writes are ignored while the master is enabled.
// - Divider bit zero reads zero and ignores writes.
// - A zero divider stops the serial bit clock.
// - Bit clock rate is bus clock over divider, even values 2 to 65534.
// - Transmit empty event while enabled whenever fill level is at or below threshold.
// - Threshold writes at or above depth minus one are discarded.
// - Clearing enable halts transfers and flushes both FIFOs at once.
`timescale 1ns/1ps
module spisc_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Register port
  input  wire logic [spisc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [spisc_pkg::DATA_W-1:0]  wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [spisc_pkg::DATA_W-1:0]  rdata,
  // Transfer engine side
  input  wire logic                          xfer_start,
  input  wire logic                          xfer_done,
  input  wire logic [spisc_pkg::LVL_W-1:0]   tx_fifo_level,
  output logic                               master_enable,
  output logic                               fifo_flush,
  // Serial pins
  output logic      [spisc_pkg::CS_W-1:0]    chip_select_line_n,
  output logic                               sclk_out,
  // Interrupt
  output logic                               irq
);
  import spisc_pkg::*;

  logic                 enable_r;
  logic [CS_W-1:0]      sel_r;
  logic [DIV_W-1:0]     div_r;
  logic [THR_W-1:0]     thr_r;
  logic [INT_W-1:0]     stat_r;
  logic [INT_W-1:0]     mask_r;
  logic [CS_W-1:0]      cs_n_r;
  logic                 flush_r;
  logic [DATA_W-1:0]    rdata_r;
  spisc_xfer_type       state_r;
  logic [INT_W-1:0]     stat_set;
  logic                 wr_en;
  logic                 wr_sel;
  logic                 wr_div;
  logic                 wr_thr;
  logic                 wr_stat;
  logic                 wr_mask;
  logic                 start_ok;
  logic                 disabling;

  spisc_div_if dv ();

  spisc_clkdiv u_div (
    .clk (clk),
    .rst (rst),
    .dv  (dv.gen)
  );

  assign wr_en     = wr && (addr == ENABLE_OFS);
  assign wr_sel    = wr && (addr == SEL_OFS);
  assign wr_div    = wr && (addr == DIV_OFS);
  assign wr_thr    = wr && (addr == THR_OFS);
  assign wr_stat   = wr && (addr == INT_STAT_OFS);
  assign wr_mask   = wr && (addr == INT_MASK_OFS);
  assign disabling = wr_en && !wdata[EN_BIT] && enable_r;
  assign start_ok  = xfer_start && enable_r && !disabling && (state_r == SPISC_IDLE);

  assign master_enable      = enable_r;
  assign fifo_flush         = flush_r;
  assign chip_select_line_n = cs_n_r;
  assign rdata              = rdata_r;
  assign irq                = |(stat_r & mask_r);

  // Master enable; a falling write raises a one-cycle flush.
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r <= 1'b0;
      flush_r  <= 1'b0;
    end else begin
      flush_r <= disabling;
      if (wr_en) begin
        enable_r <= wdata[EN_BIT];
      end
    end
  end

  // Select field is only a staging copy; the pins take it at start.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r <= SEL_RST;
    end else if (wr_sel) begin
      sel_r <= wdata[CS_W-1:0];
    end
  end

  // Divider is frozen while enabled so a running bit clock never glitches.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= DIV_RST;
    end else if (wr_div && !enable_r) begin
      div_r <= {wdata[DIV_W-1:1], 1'b0};
    end
  end

  // Threshold write is dropped as a whole when out of range.
  always_ff @(posedge clk) begin
    if (rst) begin
      thr_r <= THR_RST;
    end else if (wr_thr && (wdata[THR_CMP_W-1:0] < THR_REJECT_MIN)) begin
      thr_r <= wdata[THR_W-1:0];
    end
  end

  // Transfer state; a start while busy is ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SPISC_IDLE;
    end else begin
      unique case (state_r)
        SPISC_IDLE: begin
          if (start_ok) begin
            state_r <= SPISC_BUSY;
          end
        end
        SPISC_BUSY: begin
          if (xfer_done || !enable_r || disabling) begin
            state_r <= SPISC_IDLE;
          end
        end
      endcase
    end
  end

  // Chip selects, active low, loaded only at a transfer start.
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_n_r <= CS_IDLE;
    end else if (!enable_r || disabling) begin
      cs_n_r <= CS_IDLE;
    end else if (start_ok) begin
      cs_n_r <= ~sel_r;
    end else if ((state_r == SPISC_BUSY) && xfer_done) begin
      cs_n_r <= CS_IDLE;
    end
  end

  assign dv.divider = div_r;
  assign dv.run     = enable_r && (state_r == SPISC_BUSY) && (div_r != DIV_RST);
  assign sclk_out   = dv.sclk;

  // Sticky events; a new event in the clearing cycle wins over the clear.
  always_comb begin
    stat_set               = '0;
    stat_set[INT_TXE_BIT]  = enable_r && ({1'b0, tx_fifo_level} <= {1'b0, thr_r});
    stat_set[INT_DONE_BIT] = (state_r == SPISC_BUSY) && xfer_done;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_r <= INT_RST;
    end else if (wr_stat) begin
      stat_r <= (stat_r & ~wdata[INT_W-1:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= INT_RST;
    end else if (wr_mask) begin
      mask_r <= wdata[INT_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_r <= RD_ZERO;
    end else begin
      unique case (addr)
        ENABLE_OFS:   rdata_r <= {{(DATA_W-1){1'b0}}, enable_r};
        SEL_OFS:      rdata_r <= {{(DATA_W-CS_W){1'b0}}, sel_r};
        DIV_OFS:      rdata_r <= {{(DATA_W-DIV_W){1'b0}}, div_r};
        THR_OFS:      rdata_r <= {{(DATA_W-THR_W){1'b0}}, thr_r};
        INT_STAT_OFS: rdata_r <= {{(DATA_W-INT_W){1'b0}}, stat_r};
        INT_MASK_OFS: rdata_r <= {{(DATA_W-INT_W){1'b0}}, mask_r};
        default:      rdata_r <= RD_ZERO;
      endcase
    end
  end

  // Checking helpers: cycles between bit clock rises within one run.
  logic [DIV_W:0] gap_r;
  logic           rise_seen_r;
  logic           sclk_d_r;

  always_ff @(posedge clk) begin
    if (rst || !dv.run) begin
      gap_r       <= '0;
      rise_seen_r <= 1'b0;
      sclk_d_r    <= 1'b0;
    end else begin
      sclk_d_r <= sclk_out;
      if (sclk_out && !sclk_d_r) begin
        gap_r       <= {{DIV_W{1'b0}}, 1'b1};
        rise_seen_r <= 1'b1;
      end else begin
        gap_r <= gap_r + {{DIV_W{1'b0}}, 1'b1};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cs_latch_a: assert property (start_ok |=> cs_n_r == ~$past(sel_r))
    else $error("chip selects did not take the select field at start");

  cs_steady_a: assert property ((wr_sel && state_r == SPISC_BUSY && !xfer_done && enable_r && !disabling)
                                |=> $stable(cs_n_r))
    else $error("select write moved chip selects mid transfer");

  div_lock_a: assert property (wr_div && enable_r |=> $stable(div_r))
    else $error("divider changed while enabled");

  div_store_a: assert property (wr_div && !enable_r |=> div_r == {$past(wdata[DIV_W-1:1]), 1'b0})
    else $error("divider store wrong or bit zero kept");

  sclk_off_a: assert property (div_r == DIV_RST |=> !sclk_out [*2])
    else $error("bit clock ran with zero divider");

  sclk_period_a: assert property (dv.run && sclk_out && !sclk_d_r && rise_seen_r |-> gap_r == {1'b0, div_r})
    else $error("bit clock period differs from divider");

  txe_event_a: assert property (enable_r && (tx_fifo_level <= thr_r) |=> stat_r[INT_TXE_BIT])
    else $error("transmit empty event missed");

  thr_reject_a: assert property (wr_thr && wdata[THR_CMP_W-1:0] >= THR_REJECT_MIN |=> $stable(thr_r))
    else $error("out of range threshold was written");

  disable_flush_a: assert property ($fell(enable_r) |-> fifo_flush && state_r == SPISC_IDLE)
    else $error("disable did not flush and halt");

  cs_release_a: assert property (state_r == SPISC_BUSY && xfer_done |=> cs_n_r == CS_IDLE)
    else $error("chip selects stayed active after completion");

  flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush pulse lasted more than one cycle");

  halt_now_a: assert property (disabling |=> state_r == SPISC_IDLE && !dv.run)
    else $error("transfer kept running after disable");

  start_refused_a: assert property (xfer_start && !enable_r |=> state_r == SPISC_IDLE)
    else $error("start accepted while disabled");

  enable_store_a: assert property (wr_en |=> enable_r == $past(wdata[EN_BIT]))
    else $error("enable bit not stored");

  sclk_quiet_a: assert property (!enable_r |=> !sclk_out)
    else $error("bit clock ran while disabled");

  sclk_idle_a: assert property (state_r == SPISC_IDLE |=> !sclk_out)
    else $error("bit clock ran between transfers");

  start_busy_a: assert property (start_ok |=> state_r == SPISC_BUSY)
    else $error("accepted start did not begin a transfer");

  cs_active_a: assert property (start_ok && sel_r != SEL_RST |=> cs_n_r != CS_IDLE)
    else $error("no chip select went active at start");

  sel_store_a: assert property (wr_sel |=> sel_r == $past(wdata[CS_W-1:0]))
    else $error("select field not stored");

  sel_keep_a: assert property (!wr_sel |=> $stable(sel_r))
    else $error("select field moved without a write");

  cs_hold_a: assert property (state_r == SPISC_BUSY && !xfer_done && enable_r && !disabling
                              |=> $stable(cs_n_r))
    else $error("chip selects moved during a transfer");

  cs_idle_a: assert property (state_r == SPISC_IDLE |-> cs_n_r == CS_IDLE)
    else $error("chip select active outside a transfer");

  cs_off_a: assert property (!enable_r |-> cs_n_r == CS_IDLE)
    else $error("chip select active while disabled");

  done_idle_a: assert property (state_r == SPISC_BUSY && xfer_done |=> state_r == SPISC_IDLE)
    else $error("transfer did not end on completion");

  div_keep_a: assert property (!wr_div |=> $stable(div_r))
    else $error("divider moved without a write");

  div_read_a: assert property (rd && addr == DIV_OFS
                               |=> rdata == {{(DATA_W-DIV_W){1'b0}}, $past(div_r)} && !rdata[0])
    else $error("divider read back wrong");

  div_zero_run_a: assert property (div_r == DIV_RST |-> !dv.run)
    else $error("bit clock generator ran with zero divider");

  gap_bound_a: assert property (dv.run && rise_seen_r |-> gap_r <= {1'b0, div_r})
    else $error("bit clock period longer than divider");

  thr_store_a: assert property (wr_thr && wdata[THR_CMP_W-1:0] < THR_REJECT_MIN
                                |=> thr_r == $past(wdata[THR_W-1:0]))
    else $error("in range threshold not stored");

  thr_range_a: assert property ({{(THR_CMP_W-THR_W){1'b0}}, thr_r} < THR_REJECT_MIN)
    else $error("threshold holds an out of range value");

  thr_keep_a: assert property (!wr_thr |=> $stable(thr_r))
    else $error("threshold moved without a write");

  txe_quiet_a: assert property (!enable_r && !stat_r[INT_TXE_BIT] |=> !stat_r[INT_TXE_BIT])
    else $error("transmit empty event raised while disabled");

  txe_clear_a: assert property (wr_stat && wdata[INT_TXE_BIT] && !stat_set[INT_TXE_BIT]
                                |=> !stat_r[INT_TXE_BIT])
    else $error("transmit empty status did not clear");

  txe_irq_a: assert property (enable_r && tx_fifo_level <= thr_r && mask_r[INT_TXE_BIT] && !wr_mask
                              |=> irq)
    else $error("unmasked transmit empty event gave no interrupt");

  start_c: cover property (start_ok ##1 state_r == SPISC_BUSY);
  sclk_c: cover property (dv.run && sclk_out && !sclk_d_r && rise_seen_r);
  thr_drop_c: cover property (wr_thr && wdata[THR_CMP_W-1:0] >= THR_REJECT_MIN);
  irq_c: cover property (irq ##1 wr_stat);
  halt_c: cover property (state_r == SPISC_BUSY && disabling);

endmodule

// ==== spisc_pkg.sv ====
/*
  Shared constants for the serial master configuration slice: register
  byte offsets, field widths and positions, reset values and the transfer
  state type. Assumes a byte-addressed register port with 32-bit data.
*/
package spisc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CS_W   = 3;
  localparam int DIV_W  = 16;
  localparam int HALF_W = 15;
  localparam int THR_W  = 4;
  localparam int LVL_W  = 4;
  localparam int INT_W  = 2;

  localparam logic [ADDR_W-1:0] ENABLE_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] SEL_OFS      = 8'h10;
  localparam logic [ADDR_W-1:0] DIV_OFS      = 8'h14;
  localparam logic [ADDR_W-1:0] THR_OFS      = 8'h18;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h44;

  localparam int EN_BIT       = 0;
  localparam int INT_TXE_BIT  = 0;
  localparam int INT_DONE_BIT = 1;
  localparam int THR_CMP_W    = 8;

  localparam logic [THR_CMP_W-1:0] TX_FIFO_DEPTH  = 8'h02;
  localparam logic [THR_CMP_W-1:0] THR_REJECT_MIN = TX_FIFO_DEPTH - 8'h01;

  localparam logic [DIV_W-1:0]  DIV_RST  = 16'h0000;
  localparam logic [HALF_W-1:0] HALF_ONE = 15'h0001;
  localparam logic [THR_W-1:0]  THR_RST  = 4'h0;
  localparam logic [CS_W-1:0]   SEL_RST  = 3'h0;
  localparam logic [CS_W-1:0]   CS_IDLE  = 3'h7;
  localparam logic [INT_W-1:0]  INT_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

  typedef enum logic {
    SPISC_IDLE = 1'b0,
    SPISC_BUSY = 1'b1
  } spisc_xfer_type;

endpackage

// ==== spisc_div_if.sv ====
/*
  Carrier between the register slice and the bit clock generator: the
  divider value, the run request and the generated bit clock.
  Assumes both ends sit on the same peripheral clock.
*/
`timescale 1ns/1ps
interface spisc_div_if;
  import spisc_pkg::*;
  logic [DIV_W-1:0] divider;
  logic             run;
  logic             sclk;
  modport ctrl (output divider, output run, input sclk);
  modport gen (input divider, input run, output sclk);
endinterface

// ==== spisc_clkdiv.sv ====
/*
  Bit clock generator: toggles the serial clock every divider/2 cycles of
  the peripheral clock while run is high, so one period is divider cycles.
  Assumes the divider is even, nonzero and steady whenever run is high.
*/
`timescale 1ns/1ps
module spisc_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divider link
  spisc_div_if.gen dv
);
  import spisc_pkg::*;

  logic [HALF_W-1:0] cnt_r;
  logic              sclk_r;
  logic [HALF_W-1:0] half_m1;

  assign half_m1 = dv.divider[DIV_W-1:1] - HALF_ONE;
  assign dv.sclk = sclk_r;

  // Stopping resets the phase, so every burst starts with a full low half.
  always_ff @(posedge clk) begin
    if (rst || !dv.run) begin
      cnt_r  <= '0;
      sclk_r <= 1'b0;
    end else if (cnt_r == half_m1) begin
      cnt_r  <= '0;
      sclk_r <= ~sclk_r;
    end else begin
      cnt_r <= cnt_r + HALF_ONE;
    end
  end

endmodule

// ==== spisc_slave_model.sv ====
/*
  Behavioural model of the serial slaves on the far side of the slice.
  It watches the active low selects and the bit clock, counting rising
  clock edges and the cycles between them while any slave is selected.
  Assumes the pins come from logic on the same peripheral clock.
*/
`timescale 1ns/1ps
module spisc_slave_model (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Serial pins
  input  wire logic [spisc_pkg::CS_W-1:0]  cs_n,
  input  wire logic                        sclk,
  // Observations
  output logic      [7:0]                  n_rise,
  output logic      [7:0]                  period
);
  import spisc_pkg::*;
  logic       sclk_q;
  logic [7:0] cnt;
  // A slave only sees edges while its select is low.
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (rst) begin
      n_rise <= 8'h00;
      period <= 8'h00;
      cnt    <= 8'h00;
    end else if (cs_n != CS_IDLE) begin
      cnt <= cnt + 8'h01;
      if (sclk && !sclk_q) begin
        n_rise <= n_rise + 8'h01;
        period <= cnt + 8'h01;
        cnt    <= 8'h00;
      end
    end
  end
endmodule

// ==== spi_master_select_clock_txthreshold_tb.sv ====
/*
  Self-checking bench for the serial master configuration slice.
  Drives the register port and the transfer engine events by non-blocking
  assignment after rising edges; assumes the slave model sits on the pins.
*/
`timescale 1ns/1ps
module spi_master_select_clock_txthreshold_tb;
  import spisc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              xfer_start = 1'b0;
  logic              xfer_done = 1'b0;
  logic [LVL_W-1:0]  tx_fifo_level = 4'h3;
  logic              master_enable;
  logic              fifo_flush;
  logic [CS_W-1:0]   chip_select_line_n;
  logic              sclk_out;
  logic              irq;
  logic [7:0]        n_rise;
  logic [7:0]        period;
  logic [7:0]        n0;
  logic [DATA_W-1:0] v;
  int                n_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  logic [7:0]        ofs [7] = '{ENABLE_OFS, SEL_OFS, DIV_OFS, THR_OFS, INT_STAT_OFS, INT_MASK_OFS, 8'h3C};

  always #10 clk = ~clk;

  spisc_top i_spisc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .xfer_start(xfer_start), .xfer_done(xfer_done), .tx_fifo_level(tx_fifo_level),
    .master_enable(master_enable), .fifo_flush(fifo_flush), .chip_select_line_n(chip_select_line_n),
    .sclk_out(sclk_out), .irq(irq));
  spisc_slave_model i_spisc_slave_model (.clk(clk), .rst(rst), .cs_n(chip_select_line_n), .sclk(sclk_out),
    .n_rise(n_rise), .period(period));

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The cycle budget covers the whole sequence several times over.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  task automatic pulse(input bit is_start);
    @(posedge clk);
    if (is_start) xfer_start <= 1'b1;
    else xfer_done <= 1'b1;
    @(posedge clk);
    xfer_start <= 1'b0;
    xfer_done  <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd_chk(ofs[i], RD_ZERO);
    chk("cs_n", 3'h7, chip_select_line_n);
    wr_reg(DIV_OFS, 32'hFFFF_FFFF);
    rd_chk(DIV_OFS, 32'h0000_FFFE);
    wr_reg(DIV_OFS, 32'h0000_0005);
    rd_chk(DIV_OFS, 32'h0000_0004);
    wr_reg(THR_OFS, 32'h0000_0001);
    rd_chk(THR_OFS, RD_ZERO);
    wr_reg(THR_OFS, 32'h0000_000F);
    rd_chk(THR_OFS, RD_ZERO);
    wr_reg(THR_OFS, 32'h0000_0100);
    rd_chk(THR_OFS, RD_ZERO);
    wr_reg(SEL_OFS, 32'hFFFF_FFFA);
    rd_chk(SEL_OFS, 32'h0000_0002);
    chk("cs_n", 3'h7, chip_select_line_n);
    wr_reg(ENABLE_OFS, 32'h0000_0001);
    wr_reg(DIV_OFS, 32'h0000_0010);
    rd_chk(DIV_OFS, 32'h0000_0004);
    wr_reg(INT_MASK_OFS, 32'h0000_0003);
    pulse(1'b1);
    chk("cs_n", 3'h5, chip_select_line_n);
    wr_reg(SEL_OFS, 32'h0000_0001);
    chk("cs_n", 3'h5, chip_select_line_n);
    repeat (12) @(posedge clk);
    #1;
    chk("period", 8'h04, period);
    pulse(1'b0);
    chk("cs_n", 3'h7, chip_select_line_n);
    rd_chk(INT_STAT_OFS, 32'h0000_0002);
    chk("irq", 1'b1, irq);
    wr_reg(INT_STAT_OFS, 32'h0000_0002);
    rd_chk(INT_STAT_OFS, RD_ZERO);
    chk("irq", 1'b0, irq);
    // Several select bits at once is the broadcast case.
    wr_reg(SEL_OFS, 32'h0000_0005);
    pulse(1'b1);
    chk("cs_n", 3'h2, chip_select_line_n);
    wr_reg(ENABLE_OFS, RD_ZERO);
    chk("flush", 1'b1, fifo_flush);
    chk("enable", 1'b0, master_enable);
    chk("cs_n", 3'h7, chip_select_line_n);
    @(posedge clk);
    #1;
    chk("flush", 1'b0, fifo_flush);
    // A start while disabled must be refused and leave every select idle.
    pulse(1'b1);
    chk("cs_n", 3'h7, chip_select_line_n);
    wr_reg(DIV_OFS, RD_ZERO);
    rd_chk(DIV_OFS, RD_ZERO);
    wr_reg(ENABLE_OFS, 32'h0000_0001);
    pulse(1'b1);
    n0 = n_rise;
    repeat (12) @(posedge clk);
    #1;
    chk("n_rise", n0, n_rise);
    chk("sclk", 1'b0, sclk_out);
    pulse(1'b0);
    wr_reg(INT_STAT_OFS, 32'h0000_0003);
    @(posedge clk);
    tx_fifo_level <= 4'h1;
    repeat (2) @(posedge clk);
    rd_chk(INT_STAT_OFS, RD_ZERO);
    chk("irq", 1'b0, irq);
    @(posedge clk);
    tx_fifo_level <= 4'h0;
    repeat (2) @(posedge clk);
    rd_chk(INT_STAT_OFS, 32'h0000_0001);
    chk("irq", 1'b1, irq);
    stop_test();
  end
endmodule
